// file: fss_pkg.sv
// package: constants and carrier types for the four-channel sample sequencer
package fss_pkg;

  localparam int unsigned FSS_RES_W      = 12;
  localparam int unsigned FSS_NUM_CH     = 4;
  localparam int unsigned FSS_CH_W       = 2;

  // conversion clock: 2.5 MHz, made from the 200 MHz core clock
  localparam int unsigned FSS_CORE_HZ    = 200000000;
  localparam int unsigned FSS_CONV_HZ    = 2500000;
  localparam int unsigned FSS_CONV_DIV   = FSS_CORE_HZ / FSS_CONV_HZ;
  localparam int unsigned FSS_DIV_W      = 7;

  // edges of the conversion clock per sequence, and per channel
  localparam int unsigned FSS_SEQ_EDGES  = 78;
  localparam int unsigned FSS_SETUP_EDGES = 2;
  localparam int unsigned FSS_CH_EDGES   = 19;
  localparam int unsigned FSS_EDGE_W     = 5;

  // start to done bound, in ns, and as core cycles
  localparam int unsigned FSS_DONE_MAX_NS = 32500;
  localparam int unsigned FSS_CLK_NS      = 5;
  localparam int unsigned FSS_DONE_MAX_CYC = FSS_DONE_MAX_NS / FSS_CLK_NS;

  localparam logic [FSS_CH_W-1:0]  FSS_PTR_RST = 2'h0;
  localparam logic [FSS_RES_W-1:0] FSS_RES_RST = 12'h000;
  localparam logic [FSS_RES_W-1:0] FSS_SAR_MSB = 12'h800;

  typedef enum logic [1:0] {
    FSS_IDLE  = 2'b00,
    FSS_SETUP = 2'b01,
    FSS_CONV  = 2'b10
  } fss_state_t;

  // host read strobes after synchronisation
  typedef struct packed {
    logic rd_n;
    logic cs_n;
  } fss_bus_t;

  // per-channel successive approximation trial state
  typedef struct packed {
    logic [FSS_RES_W-1:0] trial;
    logic [FSS_RES_W-1:0] bit_mask;
  } fss_sar_t;

endpackage

// file: fss_sar_step.sv
// one successive approximation step for a 12-bit result
`timescale 1ns/10ps
module fss_sar_step
  import fss_pkg::*;
(
  input  wire fss_sar_t             i_cur,
  input  wire logic                 i_cmp_high,
  output fss_sar_t                  o_next,
  output logic [FSS_RES_W-1:0]      o_result
);

  // keep or drop the trial bit, then try the next lower one
  always_comb begin
    o_next.trial    = i_cur.trial;
    if (!i_cmp_high) begin
      o_next.trial = i_cur.trial & ~i_cur.bit_mask;
    end
    o_next.bit_mask = i_cur.bit_mask >> 1;
    o_next.trial    = o_next.trial | (i_cur.bit_mask >> 1);
    // two's complement: flip msb of the offset-binary trial
    o_result        = o_next.trial ^ FSS_SAR_MSB;
  end

endmodule

// file: fss_sequencer.sv
// four-channel sample sequencer: start, sar sequence, result store, reads
// Operation
// - rising edge of sample_start_n starts a sequence, no other edge
// - that same edge switches all four track/holds to hold together
// - channels convert in order one, two, three, four automatically
// - each channel resolved by 12-bit successive approximation
// - each result kept in its own register until read
// - done_n goes low only after all four conversions finish
// - sequence lasts 78 or 79 conversion clock rising edges
// - start to done within 32.5 us at 2.5 MHz conversion clock
// - four reads at one address return four words, pointer advancing
// - reads after a conversion return channel 1, 2, 3, then 4
// - no way exists to select one result register directly
// - 12 three-state result outputs, bit 0 lsb, enabled only on reads
// - outputs enabled only while read strobe and chip select low
// - results are two's complement, bit 11 the msb
// - done_n returns high on read strobe fall of first read
// - read pointer returns to channel 1 on each start rising edge
`timescale 1ns/10ps
module fss_sequencer
  import fss_pkg::*;
#(
  parameter int unsigned RES_W = FSS_RES_W
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_clk_en,
  input  wire logic                 i_sample_start_n,
  input  wire logic                 i_rd_n,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_cmp_high,
  output logic                      o_hold,
  output logic [FSS_CH_W-1:0]       o_conv_ch,
  output logic [RES_W-1:0]          o_dac_code,
  output logic [RES_W-1:0]          o_result_bus,
  output logic [RES_W-1:0]          o_result_bus_oe,
  output logic                      o_done_n
);

  // every flop of the block lives in this one struct
  typedef struct packed {
    logic [1:0]                     start_sync;
    logic                           start_prev;
    fss_bus_t                       bus_s1;
    fss_bus_t                       bus_s2;
    logic                           rd_act_prev;
    fss_state_t                     state;
    logic [FSS_DIV_W-1:0]           div_cnt;
    logic [FSS_EDGE_W-1:0]          edge_cnt;
    logic [FSS_CH_W-1:0]            conv_ch;
    fss_sar_t                       sar;
    logic [FSS_NUM_CH-1:0][RES_W-1:0] results;
    logic [FSS_CH_W-1:0]            rd_ptr;
    logic                           first_rd;
    logic                           hold;
    logic                           done_n;
    logic [RES_W-1:0]               bus_out;
    logic                           bus_oe;
  } fss_regs_t;

  // registered copy and its next value
  fss_regs_t  st_reg;
  fss_regs_t  st_next;
  fss_sar_t   sar_step;
  logic [RES_W-1:0] sar_result;

  // successive approximation step shared by all channels
  fss_sar_step u_sar_step (
    .i_cur      (st_reg.sar),
    .i_cmp_high (i_cmp_high),
    .o_next     (sar_step),
    .o_result   (sar_result)
  );

  // decodes shared by the next-state logic
  logic start_rise;
  logic conv_tick;
  logic rd_act;
  logic rd_fall;
  logic last_bit;

  // edges taken from second sync stages only, never from raw pins;
  // the synchronisers cost a few cycles of start and read latency
  always_comb begin
    start_rise = st_reg.start_sync[1] & ~st_reg.start_prev;
    conv_tick  = (st_reg.div_cnt == FSS_DIV_W'(FSS_CONV_DIV - 1));
    rd_act     = ~st_reg.bus_s2.rd_n & ~st_reg.bus_s2.cs_n;
    rd_fall    = rd_act & ~st_reg.rd_act_prev;
    last_bit   = (st_reg.sar.bit_mask == 12'h001);
  end

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    // two flops on the start, read and select pins before use
    st_next.start_sync = {st_reg.start_sync[0], i_sample_start_n};
    st_next.start_prev = st_reg.start_sync[1];
    st_next.bus_s1     = '{rd_n: i_rd_n, cs_n: i_cs_n};
    st_next.bus_s2     = st_reg.bus_s1;
    st_next.rd_act_prev = rd_act;

    // free-running conversion clock divider
    if (conv_tick) begin
      st_next.div_cnt = '0;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + FSS_DIV_W'(1);
    end

    // a start restarts the sequence but not the free-running divider; host must not restart mid-sequence
    // limitation: results of a cut sequence are partly overwritten
    if (start_rise) begin
      st_next.hold     = 1'b1;
      st_next.rd_ptr   = FSS_PTR_RST;
      st_next.state    = FSS_SETUP;
      st_next.edge_cnt = '0;
      st_next.conv_ch  = '0;
      st_next.done_n   = 1'b1;
      st_next.first_rd = 1'b0;
    end else begin
      case (st_reg.state)
        FSS_IDLE: begin
          st_next.hold = 1'b0;
        end
        // two edges of settle, then 4 x 19 edges: 78 in all
        // settle edges give the held inputs time before the first trial
        FSS_SETUP: begin
          if (conv_tick) begin
            if (st_reg.edge_cnt == FSS_EDGE_W'(FSS_SETUP_EDGES - 1)) begin
              st_next.state    = FSS_CONV;
              st_next.edge_cnt = '0;
              st_next.sar      = '{trial: FSS_SAR_MSB, bit_mask: FSS_SAR_MSB};
            end else begin
              st_next.edge_cnt = st_reg.edge_cnt + FSS_EDGE_W'(1);
            end
          end
        end
        FSS_CONV: begin
          if (conv_tick) begin
            st_next.edge_cnt = st_reg.edge_cnt + FSS_EDGE_W'(1);
            // 12 trial edges, then idle edges up to the channel slot
            if (st_reg.sar.bit_mask != '0) begin
              st_next.sar = sar_step;
              if (last_bit) begin
                st_next.results[st_reg.conv_ch] = sar_result;
              end
            end
            if (st_reg.edge_cnt == FSS_EDGE_W'(FSS_CH_EDGES - 1)) begin
              st_next.edge_cnt = '0;
              st_next.sar = '{trial: FSS_SAR_MSB, bit_mask: FSS_SAR_MSB};
              if (st_reg.conv_ch == FSS_CH_W'(FSS_NUM_CH - 1)) begin
                st_next.state    = FSS_IDLE;
                st_next.hold     = 1'b0;
                st_next.done_n   = 1'b0;
                st_next.first_rd = 1'b1;
              end else begin
                st_next.conv_ch = st_reg.conv_ch + FSS_CH_W'(1);
              end
            end
          end
        end
        default: begin
          st_next.state = FSS_IDLE;
        end
      endcase

      // done clears on the strobe fall of the first read
      if (rd_fall && st_reg.first_rd) begin
        st_next.done_n   = 1'b1;
        st_next.first_rd = 1'b0;
      end
      // a read during conversion still moves it; host waits for done
      // pointer advances once per read, wrapping after channel 4
      if (rd_fall) begin
        st_next.rd_ptr = st_reg.rd_ptr + FSS_CH_W'(1);
      end
    end

    // latch the addressed word at strobe fall and drive while selected
    if (rd_fall) begin
      st_next.bus_out = st_reg.results[st_reg.rd_ptr];
    end
    st_next.bus_oe = rd_act;
  end

  // single state register, frozen by the clock enable
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      // sync stages reset to the idle high level: no false edge
      st_reg <= '{
        start_sync:  2'h3,
        start_prev:  1'b1,
        bus_s1:      '{rd_n: 1'b1, cs_n: 1'b1},
        bus_s2:      '{rd_n: 1'b1, cs_n: 1'b1},
        rd_act_prev: 1'b0,
        state:       FSS_IDLE,
        div_cnt:     '0,
        edge_cnt:    '0,
        conv_ch:     '0,
        sar:         '{trial: FSS_RES_RST, bit_mask: FSS_RES_RST},
        results:     '0,
        rd_ptr:      FSS_PTR_RST,
        first_rd:    1'b0,
        hold:        1'b0,
        done_n:      1'b1,
        bus_out:     FSS_RES_RST,
        bus_oe:      1'b0
      };
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_hold          = st_reg.hold;
  assign o_conv_ch       = st_reg.conv_ch;
  assign o_dac_code      = st_reg.sar.trial;
  assign o_result_bus    = st_reg.bus_out;
  assign o_result_bus_oe = {RES_W{st_reg.bus_oe}};
  assign o_done_n        = st_reg.done_n;

endmodule

// file: fss_monitor.sv
// checker: port assertions of the sample sequencer
`timescale 1ns/10ps
module fss_monitor
  import fss_pkg::*;
#(
  parameter int unsigned RES_W = FSS_RES_W
) (
  input wire logic             i_core_clk,
  input wire logic             i_nrst,
  input wire logic             i_sample_start_n,
  input wire logic             i_rd_n,
  input wire logic             i_cs_n,
  input wire logic             o_hold,
  input wire logic [RES_W-1:0] o_result_bus,
  input wire logic [RES_W-1:0] o_result_bus_oe,
  input wire logic             o_done_n
);
  logic [12:0] hold_cyc_reg;
  logic [12:0] hold_cyc_next;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // hold time counted, since one sequence outlasts any repetition
  always_comb hold_cyc_next = o_hold ? hold_cyc_reg + 13'h1 : 13'h0;
  always_ff @(posedge i_core_clk) hold_cyc_reg <= hold_cyc_next;
  oe_equal_a: assert property (
    o_result_bus_oe == {RES_W{o_result_bus_oe[0]}}) else $error("oe split");
  oe_cause_a: assert property (
    $rose(o_result_bus_oe[0]) |-> !$past(i_rd_n) && !$past(i_cs_n))
    else $error("oe without read");
  oe_release_a: assert property (
    (i_rd_n || i_cs_n) [*5] |-> !o_result_bus_oe[0]) else $error("oe stuck");
  bus_steady_a: assert property (
    o_result_bus_oe[0] && $past(o_result_bus_oe[0]) |-> $stable(o_result_bus))
    else $error("bus moved in read");
  hold_start_a: assert property (
    $rose(i_sample_start_n) |-> ##[2:6] o_hold) else $error("no hold");
  done_hold_a: assert property (
    $fell(o_done_n) |-> $fell(o_hold)) else $error("done early");
  // between 77 and 79 ticks of 80 cycles, counted from the cycle after hold rose
  seq_len_a: assert property (
    $fell(o_done_n) |-> hold_cyc_reg >= 13'h1810 && hold_cyc_reg <= 13'h18AE)
    else $error("sequence length");
  done_clear_a: assert property (
    $rose(o_done_n) |-> !$past(i_rd_n)) else $error("done cleared");
endmodule
bind fss_sequencer fss_monitor #(.RES_W(RES_W)) u_mon (.i_core_clk,
  .i_nrst, .i_sample_start_n, .i_rd_n, .i_cs_n, .o_hold, .o_result_bus,
  .o_result_bus_oe, .o_done_n);

// file: fss_front_model.sv
// analog side model: four held inputs and the comparator
`timescale 1ns/10ps
module fss_front_model
  import fss_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_hold,
  input  wire logic [FSS_CH_W-1:0]  i_conv_ch,
  input  wire logic [FSS_RES_W-1:0] i_dac_code,
  input  wire logic [47:0]          i_level,
  output logic                      o_cmp_high
);
  logic [47:0] held_reg;
  logic        hold_reg;
  // every channel captured on the one hold edge
  always_ff @(posedge i_core_clk) begin
    hold_reg <= i_hold;
    if (i_hold && !hold_reg) begin
      held_reg <= i_level;
    end
  end
  // only the channel in conversion reaches the comparator
  assign o_cmp_high = held_reg[i_conv_ch*12 +: 12] >= i_dac_code;
endmodule

// file: four_channel_sample_sequencer_tb.sv
// testbench: start edges, sequencing and result reads
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD %0t mismatch %h %h", $time, (a), (e)); end end
module four_channel_sample_sequencer_tb;
  import fss_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        st_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        cs_n = 1'b1;
  logic [47:0] lvl = 48'h0;
  logic        cmp;
  logic        hold;
  logic        dn;
  logic [1:0]  ch;
  logic [11:0] dac;
  logic [11:0] bus;
  logic [11:0] oe;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  initial forever #2.5 clk = ~clk;
  fss_sequencer u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_sample_start_n(st_n), .i_rd_n(rd_n), .i_cs_n(cs_n), .i_cmp_high(cmp),
    .o_hold(hold), .o_conv_ch(ch), .o_dac_code(dac), .o_result_bus(bus),
    .o_result_bus_oe(oe), .o_done_n(dn));
  fss_front_model u_far (.i_core_clk(clk), .i_hold(hold), .i_conv_ch(ch),
    .i_dac_code(dac), .i_level(lvl), .o_cmp_high(cmp));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one host read; strobes stay high long enough between reads
  task automatic rd(input logic [11:0] want);
    tick(1);
    rd_n <= 1'b0;
    cs_n <= 1'b0;
    tick(5);
    #1;
    `CHK(oe, 12'hFFF)
    `CHK(bus, want)
    tick(1);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(5);
    #1;
    `CHK(oe, 12'h000)
    `CHK(dn, 1'b1)
  endtask
  task automatic rd_all(input logic [47:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      rd(v[12*(k%4) +: 12] ^ FSS_SAR_MSB);
    end
  endtask
  // inputs move after the holds close, so results show one instant
  task automatic convert(input logic [47:0] v);
    tick(1);
    lvl <= v;
    st_n <= 1'b0;
    tick(4);
    st_n <= 1'b1;
    tick(8);
    lvl <= ~v;
    #1;
    `CHK(hold, 1'b1)
    `CHK(ch, 2'h0)
    // sample done off the edge; no read until it falls
    for (int w = 0; w < 6490 && dn; w++) begin
      tick(1);
      #1;
    end
    `CHK(dn, 1'b0)
    `CHK(hold, 1'b0)
  endtask
  task automatic t_edges();
    tick(1);
    st_n <= 1'b0;
    rd_n <= 1'b0;
    tick(100);
    #1;
    `CHK(hold, 1'b0)
    `CHK(oe, 12'h000)
    tick(1);
    rd_n <= 1'b1;
    convert(48'h7FF_800_FFF_000);
    rd_all(48'h7FF_800_FFF_000, 5);
    $display("test edges done");
  endtask
  task automatic t_ptr();
    convert(48'h123_456_89A_BCD);
    rd_all(48'h123_456_89A_BCD, 2);
    convert(48'h0F0_E1E_D2D_C3C);
    rd_all(48'h0F0_E1E_D2D_C3C, 4);
    $display("test pointer done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, three sequences need about 20000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    tick(4);
    nrst <= 1'b1;
    t_edges();
    t_ptr();
    complete_run();
  end
endmodule
